// *** hdl/vm_intercept_defines.vh ***
// Constants for the guest intercept and exit-detail block
`ifndef VM_INTERCEPT_DEFINES_VH
`define VM_INTERCEPT_DEFINES_VH

// ==========================================
// Register offsets (word index on the plain port)
`define OFF_CTRL          4'h0
`define OFF_PAUSE_COUNT   4'h1
`define OFF_PAUSE_THRESH  4'h2
`define OFF_STATUS        4'h3
`define OFF_EXIT_CODE     4'h4
`define OFF_DETAIL1_LO    4'h5
`define OFF_DETAIL1_HI    4'h6
`define OFF_DETAIL2_LO    4'h7
`define OFF_DETAIL2_HI    4'h8
`define OFF_PAUSE_CNT_NOW 4'h9

// ==========================================
// Control register fields
`define CTL_MGMT_INT_ICPT   0
`define CTL_VINT_ICPT       1
`define CTL_TASK_ICPT       2
`define CTL_FREEZE_ICPT     3
`define CTL_SHUTDOWN_ICPT   4
`define CTL_PAUSE_ICPT      5
`define CTL_THRESH_SUPPORT  6
`define CTL_MGMT_MODE_LOCK  7
`define CTL_VIRT_ENABLE     8
`define CTL_WIDTH           9
`define CTL_RESET           9'h000

// ==========================================
// Exit codes
`define EXIT_NONE      4'h0
`define EXIT_MGMT_INT  4'h1
`define EXIT_VINT      4'h2
`define EXIT_TASK      4'h3
`define EXIT_FREEZE    4'h4
`define EXIT_SHUTDOWN  4'h5
`define EXIT_PAUSE     4'h6

// ==========================================
// Fault codes for store and fetch ops
`define FAULT_NONE     2'h0
`define FAULT_GP       2'h1
`define FAULT_UD       2'h2

// ==========================================
// Exit-detail field positions
`define D1_PORT_HI     63
`define D1_PORT_LO     48
`define D1_BRP_HI      47
`define D1_BRP_LO      44
`define D1_TRAP        43
`define D1_ADDR_HI     41
`define D1_ADDR_LO     39
`define D1_SIZE_HI     38
`define D1_SIZE_LO     36
`define D1_REP         35
`define D1_STR         34
`define D1_VALID       33
`define D1_DIR_IN      32
`define D1_SEG_HI      12
`define D1_SEG_LO      10
`define D1_SRC         0
`define D2_IRET        36
`define D2_FARJMP      38
`define D2_HAS_ERR     44
`define D2_RESUME      48

`endif

// *** hdl/exit_detail_store.v ***
// Two-word exit-detail storage with registered read port
`timescale 1ns/1ps
module exit_detail_store (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Write side
  input  wire        wr_en,
  input  wire [63:0] wr_d1,
  input  wire [63:0] wr_d2,
  // Read side
  input  wire [1:0]  rd_sel,
  output reg  [31:0] rd_data
);

  reg [63:0] mem [0:1];
  integer    i;

  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < 2; i = i + 1) begin
        mem[i] <= 64'h0;
      end
      rd_data <= 32'h0;
    end else begin
      if (wr_en) begin
        mem[0] <= wr_d1;
        mem[1] <= wr_d2;
      end
      rd_data <= rd_sel[0] ? mem[rd_sel[1]][63:32] : mem[rd_sel[1]][31:0];
    end
  end

endmodule // exit_detail_store

// *** hdl/vm_intercept_exit_info.v ***
// Guest intercept decision, exit-detail encoding and pause filter
// Functional notes
// [RULE_01] Without an I/O instruction, I/O bits of exit detail are left zero here.
// [RULE_02] Management-interrupt intercept ignored while mgmt_mode_lock is set.
// [RULE_03] Detail one: port 63:48, breakpoints 47:44, trap 43, width 41:39, size 38:36.
// [RULE_04] Bit 35 marks repeated port access, bit 34 string access.
// [RULE_05] Bit 33 set only when interrupt arrived during an I/O instruction.
// [RULE_06] Bit 32 gives direction: zero output, one input.
// [RULE_07] Segment number in 12:10; bits 31:13 and 9:1 zero.
// [RULE_08] Bit 0 gives source: zero internal, one external.
// [RULE_09] Virtual-interrupt exit fires before delivery; interrupt stays pending.
// [RULE_10] Task-switch intercept checked after segment checks, before state changes.
// [RULE_11] Task exit: incoming selector in detail one bits 15:0.
// [RULE_12] Task exit: error code in detail two bits 31:0.
// [RULE_13] Detail two bit 36 for interrupt return, bit 38 for far jump.
// [RULE_14] Detail two bit 44 set when an error code exists.
// [RULE_15] Detail two bit 48 holds the would-be saved resume flag.
// [RULE_16] Freeze intercept evaluated on error line with ignore low and legacy mode.
// [RULE_17] Enabled shutdown intercept turns every shutdown into a guest exit.
// [RULE_18] Guest entry loads 16-bit count; pause decrements; exit at zero.
// [RULE_19] Zero count with pause intercept enabled: every pause exits.
// [RULE_20] Threshold mode: long gap reloads counter, short gap decrements.
// [RULE_21] Threshold mode: exit when counter falls below zero.
// [RULE_22] Zero threshold with support present runs the simple mode.
// [RULE_23] Store/fetch ops: general fault off level 0; opcode fault otherwise disabled.
// [RULE_24] Gap equal to threshold counts as close repeat and decrements.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "vm_intercept_defines.vh"
module vm_intercept_exit_info (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Management interrupt event
  input  wire        mgmt_interrupt,
  input  wire        mgmt_int_source,
  input  wire        io_active,
  input  wire [15:0] io_port,
  input  wire [3:0]  io_breakpoint_hits,
  input  wire        trap_flag_copy,
  input  wire [2:0]  io_addr_width,
  input  wire [2:0]  io_operand_size,
  input  wire        multi_count_io,
  input  wire        block_io_access,
  input  wire        io_dir_in,
  input  wire [2:0]  effective_sel_code,
  // Virtual interrupt
  input  wire        virt_irq_take,
  // Task switch
  input  wire        task_switch,
  input  wire        task_checks_ok,
  input  wire [15:0] task_selector,
  input  wire [31:0] task_err_code,
  input  wire        task_has_err,
  input  wire        task_from_iret,
  input  wire        task_from_farjmp,
  input  wire        resume_flag,
  // Freeze and shutdown
  input  wire        numeric_error,
  input  wire        numeric_error_ignore,
  input  wire        legacy_error_mode,
  input  wire        shutdown_req,
  // Guest entry and pause
  input  wire        guest_entry_op,
  input  wire        pause_op,
  // Store and fetch ops
  input  wire        guest_state_store_op,
  input  wire        guest_state_fetch_op,
  input  wire [1:0]  privilege_level,
  input  wire        protected_mode,
  // Results
  output reg         guest_exit_event,
  output reg  [3:0]  exit_code,
  output reg         virt_irq_block,
  output reg         task_switch_block,
  output reg         shutdown_proceed,
  output reg  [1:0]  state_op_fault,
  output reg         state_op_ok
);

  // ==========================================
  // Configuration registers
  reg [`CTL_WIDTH-1:0] ctrl_r;
  reg [15:0]           pause_count_r;
  reg [15:0]           pause_thresh_r;
  reg [3:0]            last_code_r;

  wire mgmt_mode_lock = ctrl_r[`CTL_MGMT_MODE_LOCK];
  wire virt_enable_bit = ctrl_r[`CTL_VIRT_ENABLE];
  wire pause_icpt      = ctrl_r[`CTL_PAUSE_ICPT];

  // ==========================================
  // Pause filter state
  reg [16:0] pause_cnt_r;
  reg [31:0] gap_cnt_r;
  reg        pause_seen_r;
  reg [16:0] pause_cnt_nxt;
  reg        pause_exit;

  // Threshold mode may take the counter below zero; bit 16 is its sign
  wire thresh_mode = ctrl_r[`CTL_THRESH_SUPPORT] && (pause_thresh_r != 16'h0000); // RULE_22

  always @* begin
    pause_cnt_nxt = pause_cnt_r;
    pause_exit    = 1'b0;
    if (guest_entry_op) begin
      pause_cnt_nxt = {1'b0, pause_count_r}; // RULE_18
    end else if (pause_op) begin
      if (thresh_mode) begin
        if (pause_seen_r && (gap_cnt_r > {16'h0000, pause_thresh_r})) begin
          pause_cnt_nxt = {1'b0, pause_count_r}; // RULE_20
        end else begin
          // Close repeat: step down, exit on the step from zero to minus one
          pause_cnt_nxt = pause_cnt_r - 17'h00001; // RULE_24
          pause_exit    = pause_icpt && (pause_cnt_r == 17'h00000); // RULE_21
        end
      end else begin
        // Count-only mode: a zero count makes every pause exit
        if (pause_cnt_r[15:0] == 16'h0000) begin
          pause_exit = pause_icpt; // RULE_19
        end else begin
          pause_cnt_nxt = pause_cnt_r - 17'h00001; // RULE_18
          pause_exit    = pause_icpt && (pause_cnt_r == 17'h00001);
        end
      end
    end
  end

  // ==========================================
  // Intercept decisions; priority is management, shutdown, task, freeze, virtual interrupt, pause
  // Lower exits arriving with a higher one in the same cycle are dropped; task_switch_block follows task_hit regardless
  wire mgmt_hit   = mgmt_interrupt && ctrl_r[`CTL_MGMT_INT_ICPT] && !mgmt_mode_lock; // RULE_02
  wire vint_hit   = virt_irq_take && ctrl_r[`CTL_VINT_ICPT]; // RULE_09
  wire task_hit   = task_switch && task_checks_ok && ctrl_r[`CTL_TASK_ICPT]; // RULE_10
  wire freeze_hit = numeric_error && !numeric_error_ignore && legacy_error_mode
                    && ctrl_r[`CTL_FREEZE_ICPT]; // RULE_16
  wire shut_hit   = shutdown_req && ctrl_r[`CTL_SHUTDOWN_ICPT]; // RULE_17

  reg [3:0]  code_nxt;
  reg [63:0] d1_nxt;
  reg [63:0] d2_nxt;

  // Fields left unwritten read as zero, covering the undefined I/O and error-code bits
  always @* begin
    code_nxt = `EXIT_NONE;
    d1_nxt   = 64'h0;
    d2_nxt   = 64'h0;
    if (mgmt_hit) begin
      code_nxt = `EXIT_MGMT_INT;
      d1_nxt[`D1_SRC] = mgmt_int_source; // RULE_08
      if (io_active) begin // RULE_01
        d1_nxt[`D1_PORT_HI:`D1_PORT_LO] = io_port; // RULE_03
        d1_nxt[`D1_BRP_HI:`D1_BRP_LO]   = io_breakpoint_hits;
        d1_nxt[`D1_TRAP]                = trap_flag_copy;
        d1_nxt[`D1_ADDR_HI:`D1_ADDR_LO] = io_addr_width;
        d1_nxt[`D1_SIZE_HI:`D1_SIZE_LO] = io_operand_size;
        d1_nxt[`D1_REP]                 = multi_count_io; // RULE_04
        d1_nxt[`D1_STR]                 = block_io_access;
        d1_nxt[`D1_VALID]               = 1'b1; // RULE_05
        d1_nxt[`D1_DIR_IN]              = io_dir_in; // RULE_06
        d1_nxt[`D1_SEG_HI:`D1_SEG_LO]   = effective_sel_code; // RULE_07
      end
    end else if (shut_hit) begin
      code_nxt = `EXIT_SHUTDOWN;
    end else if (task_hit) begin
      code_nxt = `EXIT_TASK;
      d1_nxt[15:0]         = task_selector; // RULE_11
      d2_nxt[31:0]         = task_has_err ? task_err_code : 32'h0; // RULE_12
      d2_nxt[`D2_IRET]     = task_from_iret; // RULE_13
      d2_nxt[`D2_FARJMP]   = task_from_farjmp;
      d2_nxt[`D2_HAS_ERR]  = task_has_err; // RULE_14
      d2_nxt[`D2_RESUME]   = resume_flag; // RULE_15
    end else if (freeze_hit) begin
      code_nxt = `EXIT_FREEZE;
    end else if (vint_hit) begin
      code_nxt = `EXIT_VINT;
    end else if (pause_exit) begin
      code_nxt = `EXIT_PAUSE;
    end
  end

  wire exit_now = (code_nxt != `EXIT_NONE);

  // ==========================================
  // Store and fetch op privilege checks
  // Opcode fault takes precedence over the privilege fault
  function [1:0] state_op_check;
    input [1:0] lvl;
    input       pmode;
    input       ven;
    begin
      if (!pmode || !ven) begin
        state_op_check = `FAULT_UD; // RULE_23
      end else if (lvl != 2'h0) begin
        state_op_check = `FAULT_GP; // RULE_23
      end else begin
        state_op_check = `FAULT_NONE;
      end
    end
  endfunction

  wire       state_op = guest_state_store_op || guest_state_fetch_op;
  wire [1:0] fault_w  = state_op_check(privilege_level, protected_mode, virt_enable_bit);

  // ==========================================
  // Exit-detail storage
  reg  [1:0]  store_sel;
  wire [31:0] store_rdata;

  // Half of the detail word that a read at this offset returns
  always @* begin
    case (reg_addr)
      `OFF_DETAIL1_HI: store_sel = 2'h1;
      `OFF_DETAIL2_LO: store_sel = 2'h2;
      `OFF_DETAIL2_HI: store_sel = 2'h3;
      default:         store_sel = 2'h0;
    endcase
  end

  // Written only when an exit fires, so the last exit's detail stays readable
  exit_detail_store u_store (
    .clk     (clk),
    .srst    (srst),
    .wr_en   (exit_now),
    .wr_d1   (d1_nxt),
    .wr_d2   (d2_nxt),
    .rd_sel  (store_sel),
    .rd_data (store_rdata)
  );

  // ==========================================
  // Configuration registers
  always @(posedge clk) begin
    if (srst) begin
      ctrl_r         <= `CTL_RESET;
      pause_count_r  <= 16'h0000;
      pause_thresh_r <= 16'h0000;
    end else if (reg_wr) begin
      // Read-only and unmapped offsets fall through to the default
      case (reg_addr)
        `OFF_CTRL:         ctrl_r         <= reg_wdata[`CTL_WIDTH-1:0];
        `OFF_PAUSE_COUNT:  pause_count_r  <= reg_wdata[15:0];
        `OFF_PAUSE_THRESH: pause_thresh_r <= reg_wdata[15:0];
        default:           ;
      endcase
    end
  end

  // ==========================================
  // Pause counter and gap timer
  always @(posedge clk) begin
    if (srst) begin
      pause_cnt_r  <= 17'h00000;
      gap_cnt_r    <= 32'h0;
      pause_seen_r <= 1'b0;
    end else begin
      pause_cnt_r <= pause_cnt_nxt;
      if (guest_entry_op) begin
        pause_seen_r <= 1'b0;
        gap_cnt_r    <= 32'h0;
      end else if (pause_op) begin
        // Start at one so the next pause sees the full cycle distance
        pause_seen_r <= 1'b1;
        gap_cnt_r    <= 32'h1; // RULE_20
      end else if (gap_cnt_r != 32'hFFFFFFFF) begin
        // Saturate so a long idle stretch never wraps into a short gap
        gap_cnt_r <= gap_cnt_r + 32'h1;
      end
    end
  end

  // ==========================================
  // Result outputs, one cycle after the cause
  always @(posedge clk) begin
    if (srst) begin
      last_code_r       <= `EXIT_NONE;
      guest_exit_event  <= 1'b0;
      exit_code         <= `EXIT_NONE;
      virt_irq_block    <= 1'b0;
      task_switch_block <= 1'b0;
      shutdown_proceed  <= 1'b0;
      state_op_fault    <= `FAULT_NONE;
      state_op_ok       <= 1'b0;
    end else begin
      if (exit_now) begin
        last_code_r <= code_nxt;
      end
      guest_exit_event  <= exit_now;
      exit_code         <= code_nxt;
      virt_irq_block    <= vint_hit && (code_nxt == `EXIT_VINT); // RULE_09
      task_switch_block <= task_hit; // RULE_10
      shutdown_proceed  <= shutdown_req && !shut_hit; // RULE_17
      state_op_fault    <= state_op ? fault_w : `FAULT_NONE;
      state_op_ok       <= state_op && (fault_w == `FAULT_NONE);
    end
  end

  // ==========================================
  // Register read path, data one cycle after strobe
  reg        rd_q_r;
  reg [3:0]  rd_addr_r;
  reg [31:0] rd_local_r;

  always @(posedge clk) begin
    if (srst) begin
      rd_q_r     <= 1'b0;
      rd_addr_r  <= 4'h0;
      rd_local_r <= 32'h0;
    end else begin
      rd_q_r    <= reg_rd;
      rd_addr_r <= reg_addr;
      case (reg_addr)
        `OFF_CTRL:          rd_local_r <= {23'h0, ctrl_r};
        `OFF_PAUSE_COUNT:   rd_local_r <= {16'h0, pause_count_r};
        `OFF_PAUSE_THRESH:  rd_local_r <= {16'h0, pause_thresh_r};
        `OFF_STATUS:        rd_local_r <= {30'h0, thresh_mode, pause_cnt_r[16]};
        `OFF_EXIT_CODE:     rd_local_r <= {28'h0, last_code_r};
        `OFF_PAUSE_CNT_NOW: rd_local_r <= {15'h0, pause_cnt_r};
        default:            rd_local_r <= 32'h0;
      endcase
    end
  end

  // Detail words come from the store's read register, the rest from rd_local_r
  wire rd_is_store = (rd_addr_r >= `OFF_DETAIL1_LO) && (rd_addr_r <= `OFF_DETAIL2_HI);

  // Zero outside the cycle after a read strobe
  always @* begin
    if (!rd_q_r) begin
      reg_rdata = 32'h0;
    end else if (rd_is_store) begin
      reg_rdata = store_rdata;
    end else begin
      reg_rdata = rd_local_r;
    end
  end

endmodule // vm_intercept_exit_info

// *** tb/vm_intercept_exit_info_props.sv ***
// Assertions for the guest intercept block
`timescale 1ns/1ps
`include "vm_intercept_defines.vh"
module vm_intercept_exit_info_props (
  // Clock, reset, register writes
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Events
  input wire logic        mgmt_interrupt,
  input wire logic        virt_irq_take,
  input wire logic        task_switch,
  input wire logic        task_checks_ok,
  input wire logic        numeric_error,
  input wire logic        numeric_error_ignore,
  input wire logic        legacy_error_mode,
  input wire logic        shutdown_req,
  input wire logic        pause_op,
  input wire logic        guest_state_store_op,
  input wire logic        guest_state_fetch_op,
  input wire logic [1:0]  privilege_level,
  input wire logic        protected_mode,
  // Results
  input wire logic        guest_exit_event,
  input wire logic [3:0]  exit_code,
  input wire logic        virt_irq_block,
  input wire logic        task_switch_block,
  input wire logic        shutdown_proceed,
  input wire logic [1:0]  state_op_fault,
  input wire logic        state_op_ok
);
  // ======
  // Shadow of the control register
  logic [8:0] ctrl_r;
  always @(posedge clk) begin
    if (srst)
      ctrl_r <= `CTL_RESET;
    else if (reg_wr && reg_addr == `OFF_CTRL)
      ctrl_r <= reg_wdata[8:0];
  end
  wire mg = mgmt_interrupt && ctrl_r[0] && !ctrl_r[7];
  wire fz = numeric_error && !numeric_error_ignore && legacy_error_mode && ctrl_r[3];
  wire so = guest_state_store_op || guest_state_fetch_op;
  wire hi = mg || shutdown_req || task_switch;
  // ======
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence mgmt_exit_s;
    guest_exit_event && exit_code == `EXIT_MGMT_INT;
  endsequence
  sequence task_exit_s;
    task_switch_block && exit_code == `EXIT_TASK;
  endsequence
  mgmt_exit_a: assert property (mg |=> mgmt_exit_s)
    else $error("Management intercept missed");
  mgmt_lock_a: assert property (mgmt_interrupt && ctrl_r[7] |=> exit_code != `EXIT_MGMT_INT)
    else $error("Locked management intercept taken");
  shut_exit_a: assert property (shutdown_req && ctrl_r[4] && !mg |=> !shutdown_proceed && exit_code == `EXIT_SHUTDOWN)
    else $error("Shutdown not turned into exit");
  task_block_a: assert property (task_switch && task_checks_ok && ctrl_r[2] && !mg && !shutdown_req |=> task_exit_s)
    else $error("Task switch not blocked");
  task_early_a: assert property (task_switch && !task_checks_ok |=> !task_switch_block)
    else $error("Task intercept before checks");
  freeze_exit_a: assert property (fz && !hi |=> exit_code == `EXIT_FREEZE)
    else $error("Freeze intercept missed");
  vint_hold_a: assert property (virt_irq_take && ctrl_r[1] && !hi && !numeric_error |=> virt_irq_block && exit_code == `EXIT_VINT)
    else $error("Virtual interrupt not held");
  pause_cause_a: assert property (exit_code == `EXIT_PAUSE |-> $past(pause_op) && $past(ctrl_r[5]))
    else $error("Pause exit without cause");
  state_gp_a: assert property (so && privilege_level != 2'h0 && protected_mode && ctrl_r[8] |=> state_op_fault == `FAULT_GP)
    else $error("Missing general fault");
  state_ud_a: assert property (so && privilege_level == 2'h0 && !(protected_mode && ctrl_r[8]) |=> state_op_fault == `FAULT_UD)
    else $error("Missing opcode fault");
endmodule // vm_intercept_exit_info_props

// *** tb/vm_intercept_exit_info_bench.sv ***
// Self-checking bench for the guest intercept block
`timescale 1ns/1ps
`include "vm_intercept_defines.vh"
module vm_intercept_exit_info_bench;
  logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, mgmt_interrupt = 0, mgmt_int_source = 0, io_active = 0;
  logic        trap_flag_copy = 0, multi_count_io = 0, block_io_access = 0, io_dir_in = 0, virt_irq_take = 0;
  logic        task_switch = 0, task_checks_ok = 0, task_has_err = 0, task_from_iret = 0, task_from_farjmp = 0;
  logic        resume_flag = 0, numeric_error = 0, numeric_error_ignore = 0, legacy_error_mode = 0, pause_op = 0;
  logic        shutdown_req = 0, guest_entry_op = 0, guest_state_store_op = 0, guest_state_fetch_op = 0;
  logic        protected_mode = 0, guest_exit_event, virt_irq_block, task_switch_block, shutdown_proceed, state_op_ok;
  logic [31:0] reg_wdata = 0, task_err_code = 0, reg_rdata, d;
  logic [15:0] io_port = 0, task_selector = 0;
  logic [3:0]  reg_addr = 0, io_breakpoint_hits = 0, exit_code;
  logic [2:0]  io_addr_width = 0, io_operand_size = 0, effective_sel_code = 0;
  logic [1:0]  privilege_level = 0, state_op_fault;
  int          bad_count = 0, total_checks = 0, cyc = 0, k;

  vm_intercept_exit_info u_vm_intercept_exit_info (.*);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      test_done;
    end
  end

  // ======
  // Access and check tasks
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task go;
    @(posedge clk);
    {mgmt_interrupt, virt_irq_take, task_switch, numeric_error, shutdown_req} <= 0;
    {guest_entry_op, pause_op, guest_state_store_op, guest_state_fetch_op} <= 0;
    #1;
  endtask
  task ex(input logic [3:0] c);
    chk("exit_event", guest_exit_event, c != 0);
    chk("exit_code", exit_code, c);
  endtask
  task pz(input logic [3:0] c);
    @(posedge clk);
    pause_op <= 1;
    go;
    ex(c);
  endtask
  task ent;
    @(posedge clk);
    guest_entry_op <= 1;
    go;
  endtask
  task tend(input string n);
    $display("Test %s done", n);
  endtask
  task test_done;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ======
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    rd(`OFF_CTRL);
    chk("ctrl", d, 0);
    wr(`OFF_DETAIL1_LO, 32'hFFFFFFFF);
    rd(`OFF_DETAIL1_LO);
    chk("detail1_ro", d, 0);
    rd(4'hF);
    chk("unmapped", d, 0);
    wr(`OFF_CTRL, 32'h13F);
    tend("registers");
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      {mgmt_interrupt, io_active, mgmt_int_source, effective_sel_code} <= {2'h3, k[0], k[0] ? 3'h2 : 3'h5};
      {io_port, io_breakpoint_hits, trap_flag_copy, io_addr_width, io_operand_size, multi_count_io, block_io_access,
       io_dir_in} <= k[0] ? {16'h5A3C, 4'h6, 1'h0, 3'h4, 3'h4, 3'h2} : {16'hA5C3, 4'h9, 1'h1, 3'h2, 3'h1, 3'h5};
      go;
      ex(1);
      rd(`OFF_DETAIL1_HI);
      chk("detail1_hi", d, {io_port, io_breakpoint_hits, trap_flag_copy, 1'b0, io_addr_width, io_operand_size,
          multi_count_io, block_io_access, 1'b1, io_dir_in});
      rd(`OFF_DETAIL1_LO);
      chk("detail1_lo", d, {19'h0, effective_sel_code, 9'h0, mgmt_int_source});
    end
    @(posedge clk);
    {mgmt_interrupt, io_active} <= 2'h2;
    go;
    ex(1);
    rd(`OFF_DETAIL1_HI);
    chk("detail1_valid", d[1], 0);
    wr(`OFF_CTRL, 32'h1BF);
    @(posedge clk);
    mgmt_interrupt <= 1;
    go;
    ex(0);
    wr(`OFF_CTRL, 32'h13F);
    tend("management");
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      {task_switch, task_checks_ok, task_err_code} <= {2'h3, 32'hDEADBEEF};
      {task_has_err, task_from_iret, task_from_farjmp, resume_flag} <= k[0] ? 4'hB : 4'h4;
      task_selector <= k[0] ? 16'h1234 : 16'hFFF8;
      go;
      ex(3);
      chk("task_block", task_switch_block, 1);
      rd(`OFF_DETAIL1_LO);
      chk("task_sel", d[15:0], task_selector);
      rd(`OFF_DETAIL2_HI);
      chk("task_aux", {d[16], d[12], d[6], d[4]}, {resume_flag, task_has_err, task_from_farjmp,
          task_from_iret});
      rd(`OFF_DETAIL2_LO);
      if (k)
        chk("task_err", d, task_err_code);
    end
    rd(`OFF_EXIT_CODE);
    chk("last_code", d, 3);
    @(posedge clk);
    {task_switch, task_checks_ok} <= 2'h2;
    go;
    chk("task_early", task_switch_block, 0);
    tend("task switch");
    @(posedge clk);
    {numeric_error, legacy_error_mode} <= 2'h3;
    go;
    ex(4);
    @(posedge clk);
    {numeric_error, numeric_error_ignore} <= 2'h3;
    go;
    ex(0);
    @(posedge clk);
    {shutdown_req, numeric_error_ignore} <= 2'h2;
    go;
    ex(5);
    chk("shutdown_proceed", shutdown_proceed, 0);
    wr(`OFF_CTRL, 32'h12F);
    @(posedge clk);
    shutdown_req <= 1;
    go;
    chk("shutdown_proceed", shutdown_proceed, 1);
    wr(`OFF_CTRL, 32'h13F);
    @(posedge clk);
    virt_irq_take <= 1;
    go;
    ex(2);
    chk("vint_block", virt_irq_block, 1);
    tend("freeze shutdown vint");
    wr(`OFF_PAUSE_COUNT, 32'h3);
    ent;
    for (k = 0; k < 3; k++)
      pz(k == 2 ? 6 : 0);
    wr(`OFF_PAUSE_COUNT, 32'h0);
    ent;
    pz(6);
    pz(6);
    wr(`OFF_CTRL, 32'h11F);
    ent;
    pz(0);
    wr(`OFF_CTRL, 32'h17F);
    wr(`OFF_PAUSE_THRESH, 32'h5);
    wr(`OFF_PAUSE_COUNT, 32'h1);
    ent;
    pz(0);
    pz(6);
    rd(`OFF_STATUS);
    chk("status", d, 3);
    rd(`OFF_PAUSE_CNT_NOW);
    chk("pause_now", d, 32'h1FFFF);
    rd(`OFF_PAUSE_THRESH);
    chk("pause_thresh", d, 5);
    rd(`OFF_PAUSE_COUNT);
    chk("pause_count", d, 1);
    ent;
    pz(0);
    repeat (10) @(posedge clk);
    pz(0);
    pz(0);
    pz(6);
    ent;
    pz(0);
    repeat (4) @(posedge clk);
    pz(0);
    repeat (3) @(posedge clk);
    pz(0);
    pz(6);
    wr(`OFF_PAUSE_THRESH, 32'h0);
    ent;
    pz(6);
    tend("pause filter");
    for (k = 0; k < 4; k++) begin
      if (k == 3)
        wr(`OFF_CTRL, 32'h03F);
      @(posedge clk);
      {guest_state_store_op, guest_state_fetch_op} <= {k[0], !k[0]};
      privilege_level <= (k == 1) ? 2'h3 : 2'h0;
      protected_mode <= (k != 2);
      go;
      chk("state_fault", state_op_fault, k == 0 ? `FAULT_NONE : k == 1 ? `FAULT_GP : `FAULT_UD);
      chk("state_ok", state_op_ok, k == 0);
    end
    tend("state ops");
    @(posedge clk);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    rd(`OFF_CTRL);
    chk("ctrl_reset", d, 0);
    rd(`OFF_EXIT_CODE);
    chk("code_reset", d, 0);
    chk("exit_reset", guest_exit_event, 0);
    chk("fault_reset", state_op_fault, 0);
    tend("reset");
    test_done;
  end
endmodule // vm_intercept_exit_info_bench

bind vm_intercept_exit_info vm_intercept_exit_info_props u_vm_intercept_exit_info_props (.*);
